/* File: inc/ssa_defs.svh */
// Offsets, field positions and reset values of the status aggregator
// Operation
// - Top status at 02h, read clears all but bit 15
// - Top mirror at 00h, never clears
// - Clearing read drops request; mirror keeps it
// - Bit 15 follows suspend modulation enable
// - Bit 14 flags USB caused interrupt
// - Bit 13 flags warm reset command
// - Bit 12 flags NMI activity
// - Bits 11:10 and 4:2 read zero
// - Bit 9 timers, user traps, config traps
// - Bit 9 summarises second-level register
// - Bit 8 flags software generated interrupt
// - Bit 7 flags port 092h mask toggle
// - Bit 6 flags VGA timer expiry
// - Bit 5 flags retrace from serial bit 7
// - Bit 1 flags audio interface cause
// - Bit 0 power management, excluding timers
// - Second-level mirror at 04h, 15:6 reserved
// - Second-level clearing copy at 06h
// - Config trap flag, skip function 0 40h-43h
// - Three flags for user devices 1-3
// - Two flags for timer 1 and 2
// - Second-level bit positions 5 down to 0
`ifndef SSA_DEFS_SVH
`define SSA_DEFS_SVH

`define SSA_OFF_TOP_VIEW      8'h00
`define SSA_OFF_TOP_CLEAR     8'h02
`define SSA_OFF_TRAP_VIEW     8'h04
`define SSA_OFF_TRAP_CLEAR    8'h06

`define SSA_TOP_RESET         16'h0000
`define SSA_TRAP_RESET        16'h0000

`define SSA_TOP_SUSP_BIT      15
`define SSA_TOP_USB_BIT       14
`define SSA_TOP_WARM_BIT      13
`define SSA_TOP_NMI_BIT       12
`define SSA_TOP_TRAP_BIT      9
`define SSA_TOP_SOFT_BIT      8
`define SSA_TOP_A20_BIT       7
`define SSA_TOP_VGA_BIT       6
`define SSA_TOP_RETR_BIT      5
`define SSA_TOP_AUDIO_BIT     1
`define SSA_TOP_PM_BIT        0

`define SSA_TRAP_CFG_BIT      5
`define SSA_TRAP_UDEV3_BIT    4
`define SSA_TRAP_UDEV2_BIT    3
`define SSA_TRAP_UDEV1_BIT    2
`define SSA_TRAP_TMR2_BIT     1
`define SSA_TRAP_TMR1_BIT     0

`define SSA_TOP_RSVD_MASK     16'h0c1c
`define SSA_TRAP_RSVD_MASK    16'hffc0

`define SSA_A20_PORT          16'h0092
`define SSA_RETRACE_BIT       7
`define SSA_EXCL_FUNC         3'h0
`define SSA_EXCL_IDX_LO       8'h40
`define SSA_EXCL_IDX_HI       8'h43

`endif

/* File: inc/ssa_pkg.sv */
// Types shared by the status aggregator
package ssa_pkg;

  typedef enum logic [2:0] {
    SSA_SEL_NONE       = 3'h0,
    SSA_SEL_TOP_VIEW   = 3'h1,
    SSA_SEL_TOP_CLEAR  = 3'h3,
    SSA_SEL_TRAP_VIEW  = 3'h2,
    SSA_SEL_TRAP_CLEAR = 3'h6
  } ssa_sel_type;

  typedef enum logic [1:0] {
    SSA_ST_IDLE = 2'h0,
    SSA_ST_RESP = 2'h1
  } ssa_state_type;

endpackage : ssa_pkg

/* File: rtl/ssa_top.sv */
// Management-interrupt source status aggregator with mirror and clear copies
`timescale 1ns/1ps
`include "ssa_defs.svh"

module ssa_flag (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);
  logic flag_q;

  // Set takes priority so an event during the clearing read survives
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flag_q <= 1'b0;
    end else if (set_in) begin
      flag_q <= 1'b1;
    end else if (clr_in) begin
      flag_q <= 1'b0;
    end
  end

  assign flag_out = flag_q;
endmodule : ssa_flag

module ssa_top (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Memory access from the host
  input  wire logic        mem_space_en_in,
  input  wire logic [31:8] status_block_base_in,
  input  wire logic [31:0] mem_addr_in,
  input  wire logic        mem_rd_in,
  input  wire logic        mem_wr_in,
  output logic             mem_hit_out,
  output logic             mem_ack_out,
  output logic [15:0]      mem_rdata_out,
  // Configuration level
  input  wire logic        susp_mod_en_in,
  // Top-level source events, one-cycle pulses already enabled
  input  wire logic        usb_event_in,
  input  wire logic        warm_reset_event_in,
  input  wire logic        nmi_event_in,
  input  wire logic        soft_smi_event_in,
  input  wire logic        vga_timer_event_in,
  input  wire logic        audio_event_in,
  input  wire logic        pm_event_in,
  // Address-line-20 mask toggle through port 092h
  input  wire logic        a20_trap_en_in,
  input  wire logic        io_wr_in,
  input  wire logic [15:0] io_addr_in,
  output logic             addr_line20_mask_toggle_out,
  // Processor serial status link frame
  input  wire logic        retrace_en_in,
  input  wire logic        serial_valid_in,
  input  wire logic [7:0]  processor_serial_status_link_in,
  // Second-level sources
  input  wire logic        cfg_trap_in,
  input  wire logic [2:0]  cfg_trap_func_in,
  input  wire logic [7:0]  cfg_trap_index_in,
  input  wire logic [3:1]  user_trap_devices_in,
  input  wire logic        gp_timer1_event_in,
  input  wire logic        gp_timer2_event_in,
  // Interrupt request to the processor
  output logic             smi_req_out
);

  ssa_pkg::ssa_sel_type   sel;
  ssa_pkg::ssa_state_type state_q;
  ssa_pkg::ssa_state_type state_d;

  logic        base_match;
  logic        rd_take;
  logic        wr_take;
  logic        clr_top;
  logic        clr_trap;
  logic [15:0] top_set;
  logic [15:0] trap_set;
  logic [15:0] top_flags;
  logic [15:0] trap_flags;
  logic [15:0] top_view;
  logic [15:0] trap_view;
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  logic        ack_q;
  logic        a20_toggle_q;
  logic        cfg_excluded;
  logic        a20_event;
  logic        retrace_event;

  // Window decode: the status words sit in the low bytes of the block
  assign base_match = mem_space_en_in &&
                      (mem_addr_in[31:8] == status_block_base_in);
  assign mem_hit_out = base_match && (mem_rd_in || mem_wr_in);
  assign rd_take     = base_match && mem_rd_in;
  assign wr_take     = base_match && mem_wr_in && !mem_rd_in;

  always_comb begin
    sel = ssa_pkg::SSA_SEL_NONE;
    if (rd_take) begin
      case (mem_addr_in[7:0])
        `SSA_OFF_TOP_VIEW: begin
          sel = ssa_pkg::SSA_SEL_TOP_VIEW;
        end
        `SSA_OFF_TOP_CLEAR: begin
          sel = ssa_pkg::SSA_SEL_TOP_CLEAR;
        end
        `SSA_OFF_TRAP_VIEW: begin
          sel = ssa_pkg::SSA_SEL_TRAP_VIEW;
        end
        `SSA_OFF_TRAP_CLEAR: begin
          sel = ssa_pkg::SSA_SEL_TRAP_CLEAR;
        end
        default: begin
          sel = ssa_pkg::SSA_SEL_NONE;
        end
      endcase
    end
  end

  // Only the clearing copies have a side effect; mirrors are pure reads
  assign clr_top  = (sel == ssa_pkg::SSA_SEL_TOP_CLEAR);
  assign clr_trap = (sel == ssa_pkg::SSA_SEL_TRAP_CLEAR);

  // Function 0 bridge-control indexes are never trapped
  assign cfg_excluded = (cfg_trap_func_in == `SSA_EXCL_FUNC) &&
                        (cfg_trap_index_in >= `SSA_EXCL_IDX_LO) &&
                        (cfg_trap_index_in <= `SSA_EXCL_IDX_HI);

  assign a20_event = a20_trap_en_in && io_wr_in &&
                     (io_addr_in == `SSA_A20_PORT);

  assign retrace_event = retrace_en_in && serial_valid_in &&
    processor_serial_status_link_in[`SSA_RETRACE_BIT];

  always_comb begin
    trap_set = 16'h0000;
    trap_set[`SSA_TRAP_CFG_BIT]   = cfg_trap_in && !cfg_excluded;
    trap_set[`SSA_TRAP_UDEV3_BIT] = user_trap_devices_in[3];
    trap_set[`SSA_TRAP_UDEV2_BIT] = user_trap_devices_in[2];
    trap_set[`SSA_TRAP_UDEV1_BIT] = user_trap_devices_in[1];
    trap_set[`SSA_TRAP_TMR2_BIT]  = gp_timer2_event_in;
    trap_set[`SSA_TRAP_TMR1_BIT]  = gp_timer1_event_in;
  end

  always_comb begin
    top_set = 16'h0000;
    top_set[`SSA_TOP_USB_BIT]   = usb_event_in;
    top_set[`SSA_TOP_WARM_BIT]  = warm_reset_event_in;
    top_set[`SSA_TOP_NMI_BIT]   = nmi_event_in;
    // Any second-level cause also raises the summary bit
    top_set[`SSA_TOP_TRAP_BIT]  = |trap_set;
    top_set[`SSA_TOP_SOFT_BIT]  = soft_smi_event_in;
    top_set[`SSA_TOP_A20_BIT]   = a20_event;
    top_set[`SSA_TOP_VGA_BIT]   = vga_timer_event_in;
    top_set[`SSA_TOP_RETR_BIT]  = retrace_event;
    top_set[`SSA_TOP_AUDIO_BIT] = audio_event_in;
    // Timer and user-device causes never reach this bit
    top_set[`SSA_TOP_PM_BIT]    = pm_event_in;
  end

  // One sticky flag per source; the setting bit and reserved bits have none
  ssa_flag u_top_usb (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (top_set[`SSA_TOP_USB_BIT]),
    .clr_in   (clr_top),
    .flag_out (top_flags[`SSA_TOP_USB_BIT])
  );
  ssa_flag u_top_warm (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (top_set[`SSA_TOP_WARM_BIT]),
    .clr_in   (clr_top),
    .flag_out (top_flags[`SSA_TOP_WARM_BIT])
  );
  ssa_flag u_top_nmi (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (top_set[`SSA_TOP_NMI_BIT]),
    .clr_in   (clr_top),
    .flag_out (top_flags[`SSA_TOP_NMI_BIT])
  );
  ssa_flag u_top_trap (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (top_set[`SSA_TOP_TRAP_BIT]),
    .clr_in   (clr_top),
    .flag_out (top_flags[`SSA_TOP_TRAP_BIT])
  );
  ssa_flag u_top_soft (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (top_set[`SSA_TOP_SOFT_BIT]),
    .clr_in   (clr_top),
    .flag_out (top_flags[`SSA_TOP_SOFT_BIT])
  );
  ssa_flag u_top_a20 (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (top_set[`SSA_TOP_A20_BIT]),
    .clr_in   (clr_top),
    .flag_out (top_flags[`SSA_TOP_A20_BIT])
  );
  ssa_flag u_top_vga (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (top_set[`SSA_TOP_VGA_BIT]),
    .clr_in   (clr_top),
    .flag_out (top_flags[`SSA_TOP_VGA_BIT])
  );
  ssa_flag u_top_retr (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (top_set[`SSA_TOP_RETR_BIT]),
    .clr_in   (clr_top),
    .flag_out (top_flags[`SSA_TOP_RETR_BIT])
  );
  ssa_flag u_top_audio (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (top_set[`SSA_TOP_AUDIO_BIT]),
    .clr_in   (clr_top),
    .flag_out (top_flags[`SSA_TOP_AUDIO_BIT])
  );
  ssa_flag u_top_pm (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (top_set[`SSA_TOP_PM_BIT]),
    .clr_in   (clr_top),
    .flag_out (top_flags[`SSA_TOP_PM_BIT])
  );

  // Second-level flags are cleared only by their own clearing copy
  ssa_flag u_trap_cfg (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (trap_set[`SSA_TRAP_CFG_BIT]),
    .clr_in   (clr_trap),
    .flag_out (trap_flags[`SSA_TRAP_CFG_BIT])
  );
  ssa_flag u_trap_udev3 (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (trap_set[`SSA_TRAP_UDEV3_BIT]),
    .clr_in   (clr_trap),
    .flag_out (trap_flags[`SSA_TRAP_UDEV3_BIT])
  );
  ssa_flag u_trap_udev2 (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (trap_set[`SSA_TRAP_UDEV2_BIT]),
    .clr_in   (clr_trap),
    .flag_out (trap_flags[`SSA_TRAP_UDEV2_BIT])
  );
  ssa_flag u_trap_udev1 (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (trap_set[`SSA_TRAP_UDEV1_BIT]),
    .clr_in   (clr_trap),
    .flag_out (trap_flags[`SSA_TRAP_UDEV1_BIT])
  );
  ssa_flag u_trap_tmr2 (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (trap_set[`SSA_TRAP_TMR2_BIT]),
    .clr_in   (clr_trap),
    .flag_out (trap_flags[`SSA_TRAP_TMR2_BIT])
  );
  ssa_flag u_trap_tmr1 (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (trap_set[`SSA_TRAP_TMR1_BIT]),
    .clr_in   (clr_trap),
    .flag_out (trap_flags[`SSA_TRAP_TMR1_BIT])
  );

  assign top_flags[15]     = 1'h0;
  assign top_flags[11:10]  = 2'h0;
  assign top_flags[4:2]    = 3'h0;
  assign trap_flags[15:6]  = 10'h000;

  // Bit 15 is a live copy of a setting, so a read cannot clear it
  always_comb begin
    top_view = top_flags & ~`SSA_TOP_RSVD_MASK;
    top_view[`SSA_TOP_SUSP_BIT] = susp_mod_en_in;
    trap_view = trap_flags & ~`SSA_TRAP_RSVD_MASK;
  end

  // Mirror and clearing copies return the very same value
  always_comb begin
    case (sel)
      ssa_pkg::SSA_SEL_TOP_VIEW: begin
        rdata_d = top_view;
      end
      ssa_pkg::SSA_SEL_TOP_CLEAR: begin
        rdata_d = top_view;
      end
      ssa_pkg::SSA_SEL_TRAP_VIEW: begin
        rdata_d = trap_view;
      end
      ssa_pkg::SSA_SEL_TRAP_CLEAR: begin
        rdata_d = trap_view;
      end
      default: begin
        rdata_d = 16'h0000;
      end
    endcase
  end

  always_comb begin
    case (state_q)
      ssa_pkg::SSA_ST_IDLE: begin
        state_d = (rd_take || wr_take) ? ssa_pkg::SSA_ST_RESP
                                       : ssa_pkg::SSA_ST_IDLE;
      end
      ssa_pkg::SSA_ST_RESP: begin
        state_d = (rd_take || wr_take) ? ssa_pkg::SSA_ST_RESP
                                       : ssa_pkg::SSA_ST_IDLE;
      end
      default: begin
        state_d = ssa_pkg::SSA_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= ssa_pkg::SSA_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Writes are acknowledged and dropped: every word here is read-only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ack_q   <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      ack_q   <= rd_take || wr_take;
      rdata_q <= rd_take ? rdata_d : 16'h0000;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      a20_toggle_q <= 1'b0;
    end else begin
      a20_toggle_q <= a20_event;
    end
  end

  assign mem_ack_out   = ack_q && (state_q == ssa_pkg::SSA_ST_RESP);
  assign mem_rdata_out = rdata_q;
  assign addr_line20_mask_toggle_out = a20_toggle_q;

  // Request follows the sticky flags; the setting bit plays no part
  assign smi_req_out = |(top_flags & ~`SSA_TOP_RSVD_MASK);

endmodule : ssa_top

/* File: verif/ssa_props.sv */
// Port assertions for the status aggregator
`timescale 1ns/1ps
module ssa_props (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        mem_space_en_in,
  input wire logic        mem_rd_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic        mem_hit_out,
  input wire logic        mem_ack_out,
  input wire logic [15:0] mem_rdata_out,
  input wire logic        susp_mod_en_in,
  input wire logic        usb_event_in,
  input wire logic        smi_req_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_ACK: assert property (mem_hit_out |=> mem_ack_out)
    else $error("no ack after hit");
  AST_MISS: assert property (!mem_space_en_in |=> !mem_ack_out)
    else $error("ack with window off");
  AST_IDLE: assert property (!mem_ack_out |-> mem_rdata_out == 16'h0000)
    else $error("read data outside ack");
  AST_TOP_RSVD: assert property (mem_ack_out &&
    $past(mem_addr_in[7:2]) == 6'h00 |-> (mem_rdata_out & 16'h0c1c) == 0)
    else $error("reserved top bits set");
  AST_TRAP_RSVD: assert property (mem_ack_out &&
    $past(mem_addr_in[7:2]) == 6'h01 |-> mem_rdata_out[15:6] == 10'h000)
    else $error("reserved trap bits set");
  AST_SUSP: assert property (mem_ack_out && $past(mem_rd_in) &&
    $past(mem_addr_in[7:2]) == 6'h00 |->
    mem_rdata_out[15] == $past(susp_mod_en_in))
    else $error("bit 15 differs from enable");
  AST_MIRROR_KEEP: assert property (smi_req_out && mem_hit_out &&
    mem_rd_in && mem_addr_in[7:0] == 8'h00 |=> smi_req_out)
    else $error("mirror read dropped request");
  AST_USB: assert property (usb_event_in |=> smi_req_out)
    else $error("no request after usb event");
endmodule : ssa_props

bind ssa_top ssa_props u_props (.clk_in, .rst_n_in, .mem_space_en_in,
  .mem_rd_in, .mem_addr_in, .mem_hit_out, .mem_ack_out, .mem_rdata_out,
  .susp_mod_en_in, .usb_event_in, .smi_req_out);

/* File: verif/ssa_host_model.sv */
// Host handler model issuing word reads to the status block
`timescale 1ns/1ps
module ssa_host_model (
  input  wire logic        clk_in,
  input  wire logic        mem_ack_in,
  input  wire logic [15:0] mem_rdata_in,
  output logic             mem_rd_out,
  output logic [31:0]      mem_addr_out
);
  initial begin
    mem_rd_out = 1'b0;
    mem_addr_out = 32'h0000_0000;
  end
  // Mirror offsets inspect, clearing offsets acknowledge
  task automatic read_word(input logic [31:0] a, output logic [15:0] d,
                           output bit got);
    got = 1'b0;
    d = 16'h0000;
    mem_rd_out = 1'b1;
    mem_addr_out = a;
    @(posedge clk_in);
    #1;
    mem_rd_out = 1'b0;
    mem_addr_out = ~a; // Released address must not look like the last one
    // Ack and data stand between edges; sample them settled, not at an edge
    for (int n = 0; n < 3 && !got; n++) begin
      if (mem_ack_in === 1'b1) begin
        got = 1'b1;
        d = mem_rdata_in;
      end else begin
        @(posedge clk_in);
        #1;
      end
    end
  endtask : read_word
endmodule : ssa_host_model

/* File: verif/tb_top.sv */
// Self-checking bench for the status aggregator
`timescale 1ns/1ps
module tb_top;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, mem_space_en_in = 1'b1;
  logic [31:8] base = 24'h12_3456;
  logic        rd_s, ack, smi, tog, susp = 0, io_wr = 0, sv = 0, cfg = 0;
  logic        t1 = 0, t2 = 0;
  logic [31:0] addr, rs = 32'd72;
  logic [15:0] rdata, io_a = 16'h0000;
  logic [7:0]  sd = 8'h00, idx = 8'h00;
  logic [6:0]  ev = 7'h00;
  logic [2:0]  fn = 3'h0, udev = 3'h0;
  int          err_count = 0, n_checks = 0, top_m = 0, trap_m = 0;
  int          pos[7] = '{0, 1, 6, 8, 12, 13, 14};
  logic [15:0] cv[3] = '{16'h0041, 16'h0044, 16'h0141};
  always #50 clk_in = ~clk_in;
  ssa_top DUT (.clk_in, .rst_n_in, .mem_space_en_in,
    .status_block_base_in(base), .mem_addr_in(addr), .mem_rd_in(rd_s),
    .mem_wr_in(1'b0), .mem_hit_out(), .mem_ack_out(ack),
    .mem_rdata_out(rdata), .susp_mod_en_in(susp), .usb_event_in(ev[6]),
    .warm_reset_event_in(ev[5]), .nmi_event_in(ev[4]),
    .soft_smi_event_in(ev[3]), .vga_timer_event_in(ev[2]),
    .audio_event_in(ev[1]), .pm_event_in(ev[0]), .a20_trap_en_in(1'b1),
    .io_wr_in(io_wr), .io_addr_in(io_a), .addr_line20_mask_toggle_out(tog),
    .retrace_en_in(1'b1), .serial_valid_in(sv),
    .processor_serial_status_link_in(sd), .cfg_trap_in(cfg),
    .cfg_trap_func_in(fn), .cfg_trap_index_in(idx),
    .user_trap_devices_in(udev), .gp_timer1_event_in(t1),
    .gp_timer2_event_in(t2), .smi_req_out(smi));
  ssa_host_model u_host (.clk_in, .mem_ack_in(ack), .mem_rdata_in(rdata),
    .mem_rd_out(rd_s), .mem_addr_out(addr));
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] off, input bit hit_e);
    logic [15:0] d, e;
    bit got;
    e = 16'h0000;
    if (hit_e && off[7:2] == 6'h00) e = top_m[15:0] | {susp, 15'h0};
    if (hit_e && off[7:2] == 6'h01) e = trap_m[15:0];
    if (hit_e && off == 8'h02) top_m = 0;
    if (hit_e && off == 8'h06) trap_m = 0;
    u_host.read_word({base, off}, d, got);
    @(posedge clk_in);
    #1;
    check({15'h0, got}, {15'h0, hit_e});
    check(d, e);
    check({15'h0, smi}, {15'h0, top_m[14:0] != 0});
  endtask : rd
  task automatic pulse(input logic [6:0] e, input logic [4:0] t);
    ev = e;
    {udev, t2, t1} = t;
    @(posedge clk_in);
    #1;
    ev = 7'h00;
    {udev, t2, t1} = 5'h00;
    for (int i = 0; i < 7; i++) if (e[i]) top_m |= 1 << pos[i];
    trap_m |= t;
    if (t != 0) top_m |= 16'h0200;
  endtask : pulse
  task automatic ext(input int k, input logic [15:0] v);
    io_wr = k == 0;
    io_a = v;
    sv = k == 1;
    sd = v[7:0];
    cfg = k == 2;
    {fn, idx} = v[10:0];
    @(posedge clk_in);
    #1;
    {io_wr, sv, cfg} = 3'h0;
  endtask : ext
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial begin
    logic [31:0] r;
    repeat (6) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    for (int o = 0; o < 10; o += 2) rd(o[7:0], 1);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      r = xs();
      susp = r[31];
      pulse(r[6:0], r[11:7]);
      rd(8'h00, 1);
      rd(8'h04, 1);
      rd(8'h06, 1);
      rd(8'h02, 1);
    end
    $display("test sources done");
    fork
      rd(8'h02, 1);
      pulse(7'h40, 5'h00);
    join
    rd(8'h02, 1);
    ext(0, 16'h0092);
    check({15'h0, tog}, 16'h0001);
    top_m |= 16'h0080;
    ext(0, 16'h0093);
    check({15'h0, tog}, 16'h0000);
    ext(1, 16'h007f);
    ext(1, 16'h0080);
    top_m |= 16'h0020;
    rd(8'h02, 1);
    foreach (cv[i]) begin
      ext(2, cv[i]);
      if (i > 0) trap_m |= 16'h0020;
      if (i > 0) top_m |= 16'h0200;
      rd(8'h06, 1);
    end
    rd(8'h02, 1);
    mem_space_en_in = 1'b0;
    rd(8'h00, 0);
    $display("test traps done");
    complete_run();
  end
endmodule : tb_top
